// ==== fpe_pkg.sv ====
`default_nettype none
package fpe_pkg;
  localparam logic [11:0] FPE_OFS_READY = 12'h400;
  localparam logic [11:0] FPE_OFS_CONFIG = 12'h504;
  localparam logic [11:0] FPE_OFS_PAGE = 12'h508;
  localparam logic [11:0] FPE_OFS_ALL = 12'h50C;
  localparam logic [11:0] FPE_OFS_PAGE0 = 12'h510;
  localparam logic [11:0] FPE_OFS_USER = 12'h514;
  localparam logic [11:0] FPE_OFS_PART = 12'h518;
  localparam logic [11:0] FPE_OFS_PCFG = 12'h51C;
  localparam logic [31:0] FPE_RST_READY = 32'h0000_0001;
  localparam logic [1:0] FPE_RST_MODE = 2'h0;
  localparam logic [31:0] FPE_RST_PCFG = 32'h0000_000A;
  localparam logic [1:0] FPE_MODE_REN = 2'h0;
  localparam logic [1:0] FPE_MODE_WEN = 2'h1;
  localparam logic [1:0] FPE_MODE_EEN = 2'h2;
  localparam int FPE_MODE_LSB = 0;
  localparam int FPE_MODE_W = 2;
  localparam int FPE_PCFG_W = 7;
  localparam int FPE_CLK_MHZ = 200;
  // operation times in microseconds
  localparam int FPE_T_WRITE_US = 41;
  localparam int FPE_T_PAGE_US = 85000;
  localparam int FPE_T_ALL_US = 169000;
  // partial erase cfg unit, one millisecond
  localparam int FPE_T_PUNIT_US = 1000;
  localparam int FPE_CYC_WRITE = FPE_T_WRITE_US * FPE_CLK_MHZ;
  localparam int FPE_CYC_PAGE = FPE_T_PAGE_US * FPE_CLK_MHZ;
  localparam int FPE_CYC_ALL = FPE_T_ALL_US * FPE_CLK_MHZ;
  localparam int FPE_CYC_PUNIT = FPE_T_PUNIT_US * FPE_CLK_MHZ;
  typedef enum logic [2:0] {
    FPE_OP_NONE = 3'h0,
    FPE_OP_WRITE = 3'h1,
    FPE_OP_PAGE = 3'h2,
    FPE_OP_ALL = 3'h3,
    FPE_OP_USER = 3'h4,
    FPE_OP_PART = 3'h5
  } fpe_op_t;
endpackage
`default_nettype wire

// ==== fpe_timer.sv ====
`default_nettype none
module fpe_timer
  import fpe_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [31:0] len_in,
  output logic done_out,
  output logic busy_out
);
  logic [31:0] cnt_q;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 32'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in && !busy_out)
      begin
        cnt_q <= (len_in == 32'h0) ? 32'h0 : len_in - 32'h1;
        busy_out <= 1'b1;
      end
      else if (busy_out)
      begin
        if (cnt_q == 32'h0)
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== fpe_apb_if.sv ====
`default_nettype none
module fpe_apb_if
  import fpe_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_src_in,
  input wire logic known_in,
  output logic wr_out,
  output logic rd_out,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out
);
  logic acc;
  logic first;
  assign acc = psel_in && penable_in;
  // one wait state: answer registered in the first access cycle
  assign first = acc && !pready_out;
  assign wr_out = acc && pwrite_in && pready_out;
  assign rd_out = acc && !pwrite_in && pready_out;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= first;
      prdata_out <= (first && !pwrite_in && known_in) ? prdata_src_in : 32'h0;
      pslverr_out <= first && !known_in;
    end
  end
endmodule
`default_nettype wire

// ==== fpe_regs.sv ====
// Implementation choice: the APB register port.
`default_nettype none
module fpe_regs
  import fpe_pkg::*;
#(
  parameter int CYC_WRITE = FPE_CYC_WRITE,
  parameter int CYC_PAGE = FPE_CYC_PAGE,
  parameter int CYC_ALL = FPE_CYC_ALL,
  parameter int CYC_PUNIT = FPE_CYC_PUNIT
)
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic prog_req_in,
  input wire logic [31:0] prog_addr_in,
  input wire logic [31:0] prog_data_in,
  output logic prog_ack_out,
  output logic prog_fault_out,
  output logic flash_we_out,
  output logic [31:0] flash_addr_out,
  output logic [31:0] flash_data_out,
  output logic flash_erase_out,
  output logic [2:0] flash_op_out,
  output logic [1:0] mode_out
);
  import fpe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic wr;
  logic rd;
  logic known;
  logic [31:0] rdata;
  logic [1:0] mode_q;
  logic [31:0] page_q;
  logic [31:0] page0_q;
  logic [31:0] all_q;
  logic [31:0] user_q;
  logic [31:0] part_q;
  logic [FPE_PCFG_W-1:0] pcfg_q;
  fpe_op_t op_q;
  fpe_op_t op_d;
  logic busy;
  logic done;
  logic start;
  logic [31:0] len;
  logic [31:0] tgt_d;
  logic prog_ok;

  fpe_apb_if u_apb (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .prdata_src_in(rdata),
    .known_in(known),
    .wr_out(wr),
    .rd_out(rd),
    .pready_out(pready_out),
    .prdata_out(prdata_out),
    .pslverr_out(pslverr_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode, read mux
  always_comb
  begin
    known = 1'b1;
    rdata = 32'h0;
    unique case (paddr_in)
      FPE_OFS_READY: rdata = {31'h0, !busy};
      FPE_OFS_CONFIG: rdata = {30'h0, mode_q};
      FPE_OFS_PAGE: rdata = page_q;
      FPE_OFS_ALL: rdata = all_q;
      FPE_OFS_PAGE0: rdata = page0_q;
      FPE_OFS_USER: rdata = user_q;
      FPE_OFS_PART: rdata = part_q;
      FPE_OFS_PCFG: rdata = {25'h0, pcfg_q};
      default: known = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode register
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_q <= FPE_RST_MODE;
    end
    else if (wr && paddr_in == FPE_OFS_CONFIG)
    begin
      mode_q <= pwdata_in[FPE_MODE_LSB +: FPE_MODE_W];
    end
  end
  assign mode_out = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // command decode, accepted only when idle: erase commands with erase enabled, program requests with write enabled
  always_comb
  begin
    op_d = FPE_OP_NONE;
    tgt_d = 32'h0;
    len = 32'h0;
    if (!busy && wr && mode_q == FPE_MODE_EEN)
    begin
      unique case (paddr_in)
        FPE_OFS_PAGE, FPE_OFS_PAGE0:
        begin
          op_d = FPE_OP_PAGE;
          tgt_d = pwdata_in;
          len = 32'(CYC_PAGE);
        end
        FPE_OFS_ALL:
        begin
          if (pwdata_in[0])
          begin
            op_d = FPE_OP_ALL;
            len = 32'(CYC_ALL);
          end
        end
        FPE_OFS_USER:
        begin
          if (pwdata_in[0])
          begin
            op_d = FPE_OP_USER;
            len = 32'(CYC_PAGE);
          end
        end
        FPE_OFS_PART:
        begin
          op_d = FPE_OP_PART;
          tgt_d = pwdata_in;
          len = 32'(pcfg_q) * 32'(CYC_PUNIT);
        end
        default:
        begin
          op_d = FPE_OP_NONE;
        end
      endcase
    end
    else if (!busy && prog_ok)
    begin
      op_d = FPE_OP_WRITE;
      tgt_d = prog_addr_in;
      len = 32'(CYC_WRITE);
    end
  end
  assign prog_ok = prog_req_in && mode_q == FPE_MODE_WEN &&
                   prog_addr_in[1:0] == 2'h0 && !wr;
  assign start = op_d != FPE_OP_NONE;

  fpe_timer u_tmr (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(start),
    .len_in(len),
    .done_out(done),
    .busy_out(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // stored command values
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      page_q <= 32'h0;
      page0_q <= 32'h0;
      all_q <= 32'h0;
      user_q <= 32'h0;
      part_q <= 32'h0;
      pcfg_q <= FPE_RST_PCFG[FPE_PCFG_W-1:0];
    end
    else if (wr)
    begin
      unique case (paddr_in)
        FPE_OFS_PAGE: page_q <= pwdata_in;
        FPE_OFS_PAGE0: page0_q <= pwdata_in;
        FPE_OFS_ALL: all_q <= pwdata_in;
        FPE_OFS_USER: user_q <= pwdata_in;
        FPE_OFS_PART: part_q <= pwdata_in;
        FPE_OFS_PCFG: pcfg_q <= pwdata_in[FPE_PCFG_W-1:0];
        default: page_q <= page_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation to flash array
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      op_q <= FPE_OP_NONE;
      flash_addr_out <= 32'h0;
      flash_data_out <= 32'hFFFF_FFFF;
      flash_we_out <= 1'b0;
      flash_erase_out <= 1'b0;
      prog_ack_out <= 1'b0;
      prog_fault_out <= 1'b0;
    end
    else
    begin
      prog_ack_out <= 1'b0;
      prog_fault_out <= prog_req_in && !busy &&
                        (mode_q != FPE_MODE_WEN || prog_addr_in[1:0] != 2'h0);
      flash_we_out <= 1'b0;
      flash_erase_out <= 1'b0;
      if (start)
      begin
        op_q <= op_d;
        flash_addr_out <= tgt_d;
        // program clears bits only; erase writes ones
        flash_data_out <= (op_d == FPE_OP_WRITE) ?
                          prog_data_in : 32'hFFFF_FFFF;
        flash_we_out <= op_d == FPE_OP_WRITE;
        flash_erase_out <= op_d != FPE_OP_WRITE;
        prog_ack_out <= op_d == FPE_OP_WRITE;
      end
      else if (done)
      begin
        op_q <= FPE_OP_NONE;
      end
    end
  end
  assign flash_op_out = op_q;

  ////////////////////////////////////////////////////////////////////////////
  // steps of a command start
  sequence s_erase_start;
    start && op_d != FPE_OP_WRITE;
  endsequence
  sequence s_erase_pulse;
    flash_erase_out && !flash_we_out && busy;
  endsequence
  sequence s_prog_start;
    start && op_d == FPE_OP_WRITE;
  endsequence
  sequence s_prog_pulse;
    flash_we_out && prog_ack_out && !flash_erase_out && busy;
  endsequence

  a_ready_busy: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    start |=> busy) else $error("not busy after start");
  a_cmd_refused: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (wr && busy) |-> !start) else $error("command taken while busy");
  a_mode_gate: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_erase_start |-> mode_q == FPE_MODE_EEN)
    else $error("erase without erase mode");
  a_write_gate: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_prog_start |-> mode_q == FPE_MODE_WEN)
    else $error("program without write mode");
  a_mode_read: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (rd && paddr_in == FPE_OFS_CONFIG) |->
    prdata_out == {30'h0, $past(mode_q)})
    else $error("mode readback wrong");
  a_erase_pulse: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_erase_start |=> s_erase_pulse) else $error("no erase start pulse");
  a_page_addr: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (start && op_d == FPE_OP_PAGE) |=> flash_addr_out == $past(pwdata_in))
    else $error("wrong page address");
  a_all_zero: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (wr && paddr_in == FPE_OFS_ALL && !pwdata_in[0]) |-> !start)
    else $error("full erase on zero");
  a_user_zero: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (wr && paddr_in == FPE_OFS_USER && !pwdata_in[0]) |-> !start)
    else $error("user erase on zero");
  a_erase_ones: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    flash_erase_out |-> flash_data_out == 32'hFFFF_FFFF)
    else $error("erase data not ones");
  a_prog_pulse: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_prog_start |=> s_prog_pulse) else $error("no program start pulse");
  a_prog_align: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    flash_we_out |-> flash_addr_out[1:0] == 2'h0)
    else $error("unaligned program");
  a_ready_read: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (rd && paddr_in == FPE_OFS_READY) |-> prdata_out[0] == !$past(busy))
    else $error("ready readback wrong");
  a_pcfg_read: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (rd && paddr_in == FPE_OFS_PCFG) |->
    prdata_out == {25'h0, $past(pcfg_q)})
    else $error("partial cfg readback wrong");
endmodule
`default_nettype wire

// ==== tb_flash_program_erase_regs.sv ====
`default_nettype none
module tb_flash_program_erase_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import fpe_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic prog_req = 1'b0;
  logic [31:0] prog_addr = 32'h0000_0000;
  logic [31:0] prog_data = 32'h0000_0000;
  logic ack, fault, we, erase;
  logic [31:0] faddr, fdata;
  logic [2:0] op;
  logic [1:0] mode;
  logic erase_seen = 1'b0;
  logic we_seen = 1'b0;
  logic [2:0] op_seen = 3'h0;
  logic [31:0] addr_seen = 32'h0000_0000;
  logic [31:0] data_seen = 32'h0000_0000;
  logic [31:0] r;
  logic e;
  int error_cnt = 0;
  int n_compared = 0;
  logic [11:0] t_ofs [8] = '{12'h508, 12'h510, 12'h50C, 12'h514, 12'h518,
    12'h508, 12'h50C, 12'h514};
  logic [31:0] t_dat [8] = '{32'h0000_1000, 32'h0000_2000, 32'h0000_0001,
    32'h0000_0001, 32'h0000_3000, 32'h0000_4000, 32'h0000_0000,
    32'h0000_0000};
  logic [1:0] t_mode [8] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h2, 2'h2};
  logic [2:0] t_op [8] = '{3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0, 3'h0};

  always #2.5 sys_clk_in = ~sys_clk_in;

  fpe_regs #(.CYC_WRITE(20), .CYC_PAGE(50), .CYC_ALL(80), .CYC_PUNIT(5))
  i_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .prog_req_in(prog_req),
    .prog_addr_in(prog_addr), .prog_data_in(prog_data),
    .prog_ack_out(ack), .prog_fault_out(fault), .flash_we_out(we),
    .flash_addr_out(faddr), .flash_data_out(fdata),
    .flash_erase_out(erase), .flash_op_out(op), .mode_out(mode)
  );

  ////////////////////////////////////////////////////////////////////////
  // sticky capture of start pulses
  always @(posedge sys_clk_in)
  begin
    if (erase === 1'b1 || we === 1'b1)
    begin
      erase_seen <= erase;
      we_seen <= we;
      op_seen <= op;
      addr_seen <= faddr;
      data_seen <= fdata;
    end
  end

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic clr();
    @(posedge sys_clk_in);
    erase_seen <= 1'b0;
    we_seen <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      bus(1'b0, FPE_OFS_READY, 32'h0);
      n++;
    end
    while (r !== 32'h0000_0001 && n < 80);
    if (n >= 80)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask

  task automatic prog(input logic [31:0] a, input logic [31:0] d,
    input logic exp_ack);
    int n;
    n = 0;
    prog_req <= 1'b1;
    prog_addr <= a;
    prog_data <= d;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (ack !== 1'b1 && fault !== 1'b1 && n < 20);
    if (ack !== 1'b1 && fault !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
    chk1(ack, exp_ack);
    chk1(fault, ~exp_ack);
    prog_req <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    bus(1'b0, FPE_OFS_READY, 32'h0);
    chk(r, 32'h0000_0001);
    bus(1'b0, FPE_OFS_CONFIG, 32'h0);
    chk(r, 32'h0000_0000);
    bus(1'b0, FPE_OFS_PCFG, 32'h0);
    chk(r, 32'h0000_000A);
    bus(1'b0, 12'h600, 32'h0);
    chk1(e, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, FPE_OFS_CONFIG, {30'h0, t_mode[i]});
      bus(1'b0, FPE_OFS_CONFIG, 32'h0);
      chk(r, {30'h0, t_mode[i]});
      chk({30'h0, mode}, {30'h0, t_mode[i]});
      clr();
      bus(1'b1, t_ofs[i], t_dat[i]);
      bus(1'b0, FPE_OFS_READY, 32'h0);
      chk(r, {31'h0, t_op[i] == 3'h0});
      chk1(erase_seen, t_op[i] != 3'h0);
      if (t_op[i] != 3'h0)
      begin
        chk({29'h0, op_seen}, {29'h0, t_op[i]});
        chk(data_seen, 32'hFFFF_FFFF);
        if (t_op[i] != 3'h3 && t_op[i] != 3'h4)
          chk(addr_seen, t_dat[i]);
        clr();
        bus(1'b1, t_ofs[i], t_dat[i]);
        wait_idle();
        chk1(erase_seen, 1'b0);
        chk({29'h0, op}, 32'h0);
      end
      bus(1'b1, FPE_OFS_CONFIG, 32'h0);
      $display("test erase cmd %h done", t_ofs[i]);
    end
    prog(32'h0000_1000, 32'h1234_5678, 1'b0);
    bus(1'b1, FPE_OFS_CONFIG, {30'h0, FPE_MODE_WEN});
    clr();
    prog(32'h0000_1000, 32'h1234_5678, 1'b1);
    bus(1'b0, FPE_OFS_READY, 32'h0);
    chk(r, 32'h0000_0000);
    chk1(we_seen, 1'b1);
    chk(data_seen, 32'h1234_5678);
    chk(addr_seen, 32'h0000_1000);
    wait_idle();
    prog(32'h0000_1002, 32'h0000_0000, 1'b0);
    bus(1'b1, FPE_OFS_CONFIG, {30'h0, FPE_MODE_REN});
    $display("test program done");
    wrap_up();
  end
endmodule
`default_nettype wire
